/* hw/uart_mask_regs.svh */
// register map, reset values and trigger levels of the mask/status block
`ifndef UART_MASK_REGS_SVH
`define UART_MASK_REGS_SVH

// ********************************************************************
// register offsets (3-bit register address)
// ********************************************************************
`define OFS_HOLDING 3'h0
`define OFS_INT_MASK 3'h1
`define OFS_FIFO_CTRL 3'h2
`define OFS_LINE_STATUS 3'h5

// ********************************************************************
// interrupt mask fields
// ********************************************************************
`define IMR_RX_READY 0
`define IMR_TX_EMPTY 1
`define IMR_LINE_STATUS 2
`define IMR_MODEM 3
`define IMR_SLEEP 4
`define IMR_LOW_POWER 5
`define IMR_USED_MASK 8'h3f
`define IMR_RESET 8'h00

// ********************************************************************
// fifo control fields
// ********************************************************************
`define FCR_FIFO_EN 0
`define FCR_RX_RESET 1
`define FCR_TX_RESET 2
`define FCR_DMA_MODE 3
`define FCR_BIG_FIFO 5
`define FCR_TRIG_LSB 6
`define FCR_TRIG_MSB 7
`define FCR_RESET 8'h00

// ********************************************************************
// line status fields
// ********************************************************************
`define LSR_DATA_READY 0
`define LSR_OVERRUN 1
`define LSR_PARITY 2
`define LSR_FRAMING 3
`define LSR_BREAK 4
`define LSR_THR_EMPTY 5
`define LSR_TX_IDLE 6
`define LSR_FIFO_ERR 7

// ********************************************************************
// interrupt status codes (bits 3:0, bit 0 high = nothing pending)
// ********************************************************************
`define ISR_NONE 4'h1
`define ISR_LINE 4'h6
`define ISR_RX 4'h4
`define ISR_TIMEOUT 4'hc
`define ISR_TX 4'h2
`define ISR_MODEM 4'h0

// ********************************************************************
// fifo sizes and receive trigger levels
// ********************************************************************
`define DEPTH_SMALL 7'h10
`define DEPTH_BIG 7'h40
`define DEPTH_OFF 7'h01
`define TRIG_S0 7'h01
`define TRIG_S1 7'h04
`define TRIG_S2 7'h08
`define TRIG_S3 7'h0e
`define TRIG_B0 7'h01
`define TRIG_B1 7'h10
`define TRIG_B2 7'h20
`define TRIG_B3 7'h38

`endif

/* hw/uart_mask_pkg.sv */
// types shared by the interrupt mask, line status and dma request block
package uart_mask_pkg;
   typedef logic [2:0] reg_addr_t;
   typedef logic [7:0] byte_t;
   typedef logic [6:0] level_t;
   typedef enum logic [0:0] {
      DMA_IDLE = 1'b0,
      DMA_REQ = 1'b1
   } dma_state_e;
endpackage

/* hw/fill_counter.sv */
// occupancy counter for one fifo, bounded by a run-time capacity
`timescale 1ns/1ps
module fill_counter #(
   parameter int WIDTH = 7
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [WIDTH-1:0] cap_in,
   output logic [WIDTH-1:0] count_out,
   output logic full_out
);
   logic [WIDTH-1:0] count_q;
   logic do_push;
   logic do_pop;

   // a push into a full fifo is dropped; the datapath reports it as overrun
   assign do_push = push_in && (count_q < cap_in);
   assign do_pop = pop_in && (count_q != '0);

   always_ff @(posedge clk_in) begin
      if (rst_in || clear_in) begin
         count_q <= '0;
      end else if (do_push && !do_pop) begin
         count_q <= count_q + WIDTH'(1);
      end else if (do_pop && !do_push) begin
         count_q <= count_q - WIDTH'(1);
      end
   end

   assign count_out = count_q;
   assign full_out = (count_q >= cap_in);
endmodule // fill_counter

/* hw/rx_error_tracker.sv */
// remembers which queued receive characters carry an error
`timescale 1ns/1ps
module rx_error_tracker #(
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic push_in,
   input wire logic push_err_in,
   input wire logic pop_in,
   output logic any_err_out
);
   logic [DEPTH-1:0] flag_q;
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] err_cnt_q;
   logic head_err;

   assign head_err = flag_q[rd_q];

   always_ff @(posedge clk_in) begin
      if (rst_in || clear_in) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push_in) begin
            wr_q <= wr_q + AW'(1);
         end
         if (pop_in) begin
            rd_q <= rd_q + AW'(1);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flag_q <= '0;
      end else if (push_in) begin
         flag_q[wr_q] <= push_err_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || clear_in) begin
         err_cnt_q <= '0;
      end else if ((push_in && push_err_in) && !(pop_in && head_err)) begin
         err_cnt_q <= err_cnt_q + (AW+1)'(1);
      end else if ((pop_in && head_err) && !(push_in && push_err_in)) begin
         err_cnt_q <= err_cnt_q - (AW+1)'(1);
      end
   end

   assign any_err_out = (err_cnt_q != '0);
endmodule // rx_error_tracker

/* hw/uart_int_mask.sv */
// interrupt masking, fifo status reporting and dma request pins of a fifo uart
`timescale 1ns/1ps
`include "uart_mask_regs.svh"

module uart_int_mask #(
   parameter int FIFO_DEPTH = 64,
   parameter int LW = 7
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire uart_mask_pkg::reg_addr_t addr_in,
   input wire uart_mask_pkg::byte_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output uart_mask_pkg::byte_t rdata_out,
   input wire logic rx_push_in,
   input wire uart_mask_pkg::byte_t rx_data_in,
   input wire logic rx_overrun_in,
   input wire logic rx_parity_err_in,
   input wire logic rx_framing_err_in,
   input wire logic rx_break_in,
   input wire logic rx_timeout_in,
   input wire logic tx_pop_in,
   input wire logic tx_shift_busy_in,
   input wire logic modem_change_in,
   output logic rx_pop_out,
   output logic tx_push_out,
   output uart_mask_pkg::byte_t tx_data_out,
   output logic rx_fifo_reset_out,
   output logic tx_fifo_reset_out,
   output logic low_power_en_out,
   output logic sleep_en_out,
   output logic irq_out,
   output logic transmit_dma_request_n_out,
   output logic receive_dma_request_n_out
);
   import uart_mask_pkg::*;

   // ********************************
   // trigger decode
   // ********************************
   function automatic level_t trigger_level(input logic [1:0] sel, input logic big);
      level_t lvl;
      case ({big, sel})
         3'h1: lvl = `TRIG_S1;
         3'h2: lvl = `TRIG_S2;
         3'h3: lvl = `TRIG_S3;
         3'h4: lvl = `TRIG_B0;
         3'h5: lvl = `TRIG_B1;
         3'h6: lvl = `TRIG_B2;
         3'h7: lvl = `TRIG_B3;
         default: lvl = `TRIG_S0;
      endcase
      return lvl;
   endfunction

   // ********************************
   // registers
   // ********************************
   byte_t imr_q;
   byte_t fcr_q;
   byte_t rdata_q;
   byte_t tx_data_q;
   logic [4:1] err_q;
   logic rx_clr_q;
   logic tx_clr_q;
   dma_state_e rx_dma_q;
   dma_state_e rx_dma_d;
   dma_state_e tx_dma_q;
   dma_state_e tx_dma_d;
   logic wr_imr;
   logic wr_fcr;
   logic wr_thr;
   logic rd_rhr;
   logic rd_lsr;
   logic fifo_en;
   logic dma_mode1;
   level_t cap;
   level_t trig;
   level_t rx_count;
   level_t tx_count;
   logic rx_full;
   logic tx_full;
   logic fifo_err;
   logic rx_push_err;
   byte_t line_status_register;
   byte_t interrupt_status_register;
   logic rx_pend;
   logic tx_pend;
   logic ls_pend;
   logic ms_pend;
   logic [3:0] isr_code;

   always_comb begin
      wr_imr = 1'b0;
      wr_fcr = 1'b0;
      wr_thr = 1'b0;
      rd_rhr = 1'b0;
      rd_lsr = 1'b0;
      if (addr_in == `OFS_HOLDING) begin
         wr_thr = wr_in;
         rd_rhr = rd_in;
      end else if (addr_in == `OFS_INT_MASK) begin
         wr_imr = wr_in;
      end else if (addr_in == `OFS_FIFO_CTRL) begin
         wr_fcr = wr_in;
      end else if (addr_in == `OFS_LINE_STATUS) begin
         rd_lsr = rd_in;
      end
   end

   // bits 7:6 are unused and always read back as zero
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         imr_q <= `IMR_RESET;
      end else if (wr_imr) begin
         imr_q <= wdata_in & `IMR_USED_MASK;
      end
   end
   // other fields except the reset bits only take effect when the enable bit is written as one;
   // the two reset bits are self-clearing and never stored
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fcr_q <= `FCR_RESET;
      end else if (wr_fcr) begin
         if (wdata_in[`FCR_FIFO_EN]) begin
            fcr_q <= {wdata_in[7:5], 1'b0, wdata_in[3], 2'b00, 1'b1};
         end else begin
            fcr_q <= `FCR_RESET;
         end
      end
   end
   // disabling the fifos also flushes them
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_clr_q <= 1'b0;
         tx_clr_q <= 1'b0;
      end else begin
         rx_clr_q <= wr_fcr && (wdata_in[`FCR_RX_RESET] || (wdata_in[`FCR_FIFO_EN] != fcr_q[`FCR_FIFO_EN]));
         tx_clr_q <= wr_fcr && (wdata_in[`FCR_TX_RESET] || (wdata_in[`FCR_FIFO_EN] != fcr_q[`FCR_FIFO_EN]));
      end
   end

   assign rx_fifo_reset_out = rx_clr_q;
   assign tx_fifo_reset_out = tx_clr_q;
   assign low_power_en_out = imr_q[`IMR_LOW_POWER];
   assign sleep_en_out = imr_q[`IMR_SLEEP];

   assign fifo_en = fcr_q[`FCR_FIFO_EN];
   assign dma_mode1 = fifo_en && fcr_q[`FCR_DMA_MODE];
   // without fifos the holding register acts as a one-entry fifo
   assign cap = !fifo_en ? `DEPTH_OFF : (fcr_q[`FCR_BIG_FIFO] ? `DEPTH_BIG : `DEPTH_SMALL);
   assign trig = !fifo_en ? `TRIG_S0 :
      trigger_level(fcr_q[`FCR_TRIG_MSB:`FCR_TRIG_LSB], fcr_q[`FCR_BIG_FIFO]);

   // ********************************
   // fifo occupancy
   // ********************************
   assign rx_pop_out = rd_rhr && (rx_count != '0);
   assign tx_push_out = wr_thr && !tx_full;
   assign rx_push_err = rx_parity_err_in || rx_framing_err_in || rx_break_in;

   fill_counter #(
      .WIDTH(LW)
   ) rx_level (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(rx_clr_q),
      .push_in(rx_push_in),
      .pop_in(rx_pop_out),
      .cap_in(cap),
      .count_out(rx_count),
      .full_out(rx_full)
   );
   fill_counter #(
      .WIDTH(LW)
   ) tx_level (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(tx_clr_q),
      .push_in(tx_push_out),
      .pop_in(tx_pop_in),
      .cap_in(cap),
      .count_out(tx_count),
      .full_out(tx_full)
   );
   rx_error_tracker #(
      .DEPTH(FIFO_DEPTH),
      .AW($clog2(FIFO_DEPTH))
   ) rx_errs (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(rx_clr_q),
      .push_in(rx_push_in && !rx_full),
      .push_err_in(rx_push_err),
      .pop_in(rx_pop_out),
      .any_err_out(fifo_err)
   );

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_data_q <= 8'h00;
      end else if (tx_push_out) begin
         tx_data_q <= wdata_in;
      end
   end
   assign tx_data_out = tx_data_q;

   // ********************************
   // line status
   // ********************************
   // error bits are sticky until the status register is read; a new error
   // in the read cycle survives the clear
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         err_q <= 4'h0;
      end else begin
         err_q[`LSR_OVERRUN] <= rx_overrun_in || (err_q[`LSR_OVERRUN] && !rd_lsr);
         err_q[`LSR_PARITY] <= (rx_push_in && rx_parity_err_in) || (err_q[`LSR_PARITY] && !rd_lsr);
         err_q[`LSR_FRAMING] <= (rx_push_in && rx_framing_err_in) || (err_q[`LSR_FRAMING] && !rd_lsr);
         err_q[`LSR_BREAK] <= (rx_push_in && rx_break_in) || (err_q[`LSR_BREAK] && !rd_lsr);
      end
   end

   always_comb begin
      line_status_register = 8'h00;
      line_status_register[`LSR_DATA_READY] = (rx_count != '0);
      line_status_register[`LSR_BREAK:`LSR_OVERRUN] = err_q;
      line_status_register[`LSR_THR_EMPTY] = (tx_count == '0);
      line_status_register[`LSR_TX_IDLE] = (tx_count == '0) && !tx_shift_busy_in;
      line_status_register[`LSR_FIFO_ERR] = fifo_err;
   end

   // ********************************
   // interrupt sources
   // ********************************
   // all masks clear: nothing reaches the pin, software polls status
   always_comb begin
      rx_pend = imr_q[`IMR_RX_READY] && ((rx_count >= trig) || (fifo_en && rx_timeout_in));
      if (dma_mode1) begin
         tx_pend = imr_q[`IMR_TX_EMPTY] && (tx_count < trig);
      end else begin
         tx_pend = imr_q[`IMR_TX_EMPTY] && line_status_register[`LSR_THR_EMPTY];
      end
      ls_pend = imr_q[`IMR_LINE_STATUS] && (line_status_register[`LSR_DATA_READY] || (err_q != 4'h0));
      ms_pend = imr_q[`IMR_MODEM] && modem_change_in;
   end
   assign irq_out = rx_pend || tx_pend || ls_pend || ms_pend;

   // highest priority first; the code clears as soon as its source goes
   always_comb begin
      if (ls_pend) begin
         isr_code = `ISR_LINE;
      end else if (rx_pend && rx_count >= trig) begin
         isr_code = `ISR_RX;
      end else if (rx_pend) begin
         isr_code = `ISR_TIMEOUT;
      end else if (tx_pend) begin
         isr_code = `ISR_TX;
      end else if (ms_pend) begin
         isr_code = `ISR_MODEM;
      end else begin
         isr_code = `ISR_NONE;
      end
   end
   assign interrupt_status_register = {fifo_en, fifo_en, fifo_en && fcr_q[`FCR_BIG_FIFO], 1'b0, isr_code};

   // ********************************
   // dma request pins
   // ********************************
   // mode 1 receive: request from trigger (or timeout) until fully drained
   always_comb begin
      rx_dma_d = rx_dma_q;
      case (rx_dma_q)
         DMA_IDLE: begin
            if (dma_mode1 ? ((rx_count >= trig) || rx_timeout_in) : (rx_count != '0)) begin
               rx_dma_d = DMA_REQ;
            end
         end
         DMA_REQ: begin
            if (rx_count == '0) begin
               rx_dma_d = DMA_IDLE;
            end
         end
      endcase
   end

   // mode 1 transmit: request below trigger, hold until the fifo is full;
   // mode 0: request only while nothing at all is queued
   always_comb begin
      tx_dma_d = tx_dma_q;
      case (tx_dma_q)
         DMA_IDLE: begin
            if (dma_mode1 ? (tx_count < trig) : (tx_count == '0)) begin
               tx_dma_d = DMA_REQ;
            end
         end
         DMA_REQ: begin
            if (dma_mode1 ? tx_full : (tx_count != '0)) begin
               tx_dma_d = DMA_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_dma_q <= DMA_IDLE;
         tx_dma_q <= DMA_IDLE;
      end else begin
         rx_dma_q <= rx_dma_d;
         tx_dma_q <= tx_dma_d;
      end
   end

   assign receive_dma_request_n_out = (rx_dma_q != DMA_REQ);
   assign transmit_dma_request_n_out = (tx_dma_q != DMA_REQ);

   // ********************************
   // read data, valid only in the cycle after the read strobe
   // ********************************
   always_ff @(posedge clk_in) begin
      if (rst_in || !rd_in) begin
         rdata_q <= 8'h00;
      end else if (addr_in == `OFS_HOLDING) begin
         rdata_q <= rx_data_in;
      end else if (addr_in == `OFS_INT_MASK) begin
         rdata_q <= imr_q;
      end else if (addr_in == `OFS_FIFO_CTRL) begin
         rdata_q <= interrupt_status_register;
      end else if (addr_in == `OFS_LINE_STATUS) begin
         rdata_q <= line_status_register;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_out = rdata_q;
endmodule // uart_int_mask

/* tb/uart_int_mask_props.sv */
// port-level checker for interrupt masking, line status and dma request pins
`timescale 1ns/1ps
`include "uart_mask_regs.svh"
module uart_int_mask_props (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire uart_mask_pkg::reg_addr_t addr_in,
   input wire uart_mask_pkg::byte_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire uart_mask_pkg::byte_t rdata_out,
   input wire logic rx_push_in,
   input wire logic tx_pop_in,
   input wire logic tx_shift_busy_in,
   input wire logic modem_change_in,
   input wire logic rx_pop_out,
   input wire logic tx_push_out,
   input wire logic rx_fifo_reset_out,
   input wire logic tx_fifo_reset_out,
   input wire logic low_power_en_out,
   input wire logic sleep_en_out,
   input wire logic irq_out,
   input wire logic transmit_dma_request_n_out,
   input wire logic receive_dma_request_n_out
);
   import uart_mask_pkg::*;
   // ********************************
   // shadow state from port traffic; assumes no overfill
   // ********************************
   logic [3:0] mask_q;
   byte_t fcr_q;
   level_t rxc_q, txc_q, trig;
   logic rx_nz, tx_empty, mode1;
   logic [1:0] tx_bits;
   assign rx_nz = rxc_q != 7'h00;
   assign tx_empty = txc_q == 7'h00;
   assign tx_bits = {tx_empty & !tx_shift_busy_in, tx_empty};
   assign mode1 = fcr_q[`FCR_DMA_MODE];
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mask_q <= 4'h0;
         fcr_q <= 8'h00;
      end else if (wr_in && addr_in == `OFS_INT_MASK) begin
         mask_q <= wdata_in[3:0];
      end else if (wr_in && addr_in == `OFS_FIFO_CTRL) begin
         fcr_q <= wdata_in[0] ? (wdata_in & 8'hf9) : 8'h00;
      end
   end
   always_ff @(posedge clk_in) begin
      rxc_q <= (rst_in || rx_fifo_reset_out) ? 7'h00 : rxc_q + 7'(rx_push_in) - 7'(rx_pop_out);
      txc_q <= (rst_in || tx_fifo_reset_out) ? 7'h00 : txc_q + 7'(tx_push_out) - 7'(tx_pop_in);
   end
   always_comb begin
      case ({fcr_q[`FCR_BIG_FIFO], fcr_q[7:6]})
         3'h1: trig = `TRIG_S1;
         3'h2: trig = `TRIG_S2;
         3'h3: trig = `TRIG_S3;
         3'h5: trig = `TRIG_B1;
         3'h6: trig = `TRIG_B2;
         3'h7: trig = `TRIG_B3;
         default: trig = `TRIG_S0;
      endcase
   end
   default clocking dc @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_stat_rd;
      rd_in && addr_in == `OFS_LINE_STATUS;
   endsequence
   sequence s_mask_wr;
      wr_in && addr_in == `OFS_INT_MASK;
   endsequence
   sequence s_m1_low;
      mode1 && !receive_dma_request_n_out && rx_nz;
   endsequence
   // the pin is held in reset one edge longer than the shadow count
   sequence s_was_m0;
      !$past(rst_in) && !$past(mode1);
   endsequence
   AST_MASK_RESET: assert property ($past(rst_in) |-> !irq_out && !sleep_en_out && !low_power_en_out)
      else $error("mask outputs not clear after reset");
   AST_POWER_BITS: assert property (s_mask_wr |=> {low_power_en_out, sleep_en_out} == $past(wdata_in[5:4]))
      else $error("power enables do not follow mask write");
   AST_MODEM_IRQ: assert property (mask_q[3] && modem_change_in |-> irq_out)
      else $error("modem interrupt missing");
   AST_POLLED_QUIET: assert property (mask_q == 4'h0 |-> !irq_out)
      else $error("interrupt with all sources masked");
   AST_LINE_IRQ: assert property (mask_q[2] && rx_nz |-> irq_out)
      else $error("line status interrupt missing");
   AST_TX_IRQ: assert property (mask_q[1] && (mode1 ? txc_q < trig : tx_empty) |-> irq_out)
      else $error("transmit interrupt missing");
   AST_RX_IRQ: assert property (mask_q[0] && rxc_q >= trig |-> irq_out)
      else $error("receive trigger interrupt missing");
   AST_READY_BIT: assert property (s_stat_rd |=> rdata_out[0] == $past(rx_nz))
      else $error("data ready bit wrong");
   AST_TX_BITS: assert property (s_stat_rd |=> rdata_out[6:5] == $past(tx_bits))
      else $error("transmit empty bits wrong");
   AST_RX_DMA0: assert property (!$past(mode1) |-> receive_dma_request_n_out == !$past(rx_nz))
      else $error("receive request wrong in mode 0");
   AST_TX_DMA0: assert property (s_was_m0 |-> transmit_dma_request_n_out == !$past(tx_empty))
      else $error("transmit request wrong in mode 0");
   AST_RX_DMA1_SET: assert property (mode1 && rxc_q >= trig |=> !receive_dma_request_n_out)
      else $error("receive request not set at trigger");
   AST_RX_DMA1_HOLD: assert property (s_m1_low |=> !receive_dma_request_n_out)
      else $error("receive request released before empty");
endmodule // uart_int_mask_props

bind uart_int_mask uart_int_mask_props u_props (
   .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .rx_push_in(rx_push_in), .tx_pop_in(tx_pop_in), .tx_shift_busy_in(tx_shift_busy_in),
   .modem_change_in(modem_change_in), .rx_pop_out(rx_pop_out), .tx_push_out(tx_push_out),
   .rx_fifo_reset_out(rx_fifo_reset_out), .tx_fifo_reset_out(tx_fifo_reset_out),
   .low_power_en_out(low_power_en_out), .sleep_en_out(sleep_en_out), .irq_out(irq_out),
   .transmit_dma_request_n_out(transmit_dma_request_n_out), .receive_dma_request_n_out(receive_dma_request_n_out));

/* tb/host_bus_model.sv */
// host processor model that reaches the block registers over the plain register port
`timescale 1ns/1ps
module host_bus_model (
   input wire logic clk_in,
   input wire uart_mask_pkg::byte_t rdata_in,
   output uart_mask_pkg::reg_addr_t addr_out,
   output uart_mask_pkg::byte_t wdata_out,
   output logic wr_out,
   output logic rd_out
);
   import uart_mask_pkg::*;
   // ********************************
   // idle address is inverted after every access and data only after a write, so neither repeats the last value
   // ********************************
   initial begin
      addr_out = 3'h7;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic bus_write(input reg_addr_t a, input byte_t d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
      #1;
   endtask
   task automatic bus_read(input reg_addr_t a, output byte_t d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      #1;
      d = rdata_in;
   endtask
endmodule // host_bus_model

/* tb/uart_int_mask_test.sv */
// self-checking bench for interrupt masking, line status and dma request pins
`timescale 1ns/1ps
`include "uart_mask_regs.svh"
module uart_int_mask_test;
   import uart_mask_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   reg_addr_t addr;
   byte_t wdata, rdata, rx_data, tx_data, rd_val;
   logic wr, rd, rx_push, rx_ovr, rx_par, rx_frm, rx_brk, rx_tmo, tx_pop, tx_busy, modem;
   logic low_pwr, sleep, irq, tx_req_n, rx_req_n;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [31:0] rnd_q = 32'h0000c5dc;
   always #2 clk_in = ~clk_in;
   host_bus_model u_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd));
   uart_int_mask u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .rx_push_in(rx_push), .rx_data_in(rx_data), .rx_overrun_in(rx_ovr),
      .rx_parity_err_in(rx_par), .rx_framing_err_in(rx_frm), .rx_break_in(rx_brk), .rx_timeout_in(rx_tmo),
      .tx_pop_in(tx_pop), .tx_shift_busy_in(tx_busy), .modem_change_in(modem), .rx_pop_out(),
      .tx_push_out(), .tx_data_out(tx_data), .rx_fifo_reset_out(), .tx_fifo_reset_out(),
      .low_power_en_out(low_pwr), .sleep_en_out(sleep), .irq_out(irq),
      .transmit_dma_request_n_out(tx_req_n), .receive_dma_request_n_out(rx_req_n));
   // ********************************
   // helpers
   // ********************************
   function automatic byte_t rnd();
      rnd_q ^= rnd_q << 13;
      rnd_q ^= rnd_q >> 17;
      rnd_q ^= rnd_q << 5;
      return rnd_q[7:0];
   endfunction
   function automatic int trig_of(input logic big, input logic [1:0] code);
      int s[4] = '{1, 4, 8, 14};
      int b[4] = '{1, 16, 32, 56};
      return big ? b[code] : s[code];
   endfunction
   task automatic chk_byte(input byte_t got, input byte_t exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: pin %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input reg_addr_t a, input byte_t exp);
      u_host.bus_read(a, rd_val);
      chk_byte(rd_val, exp);
   endtask
   // errs order is break, framing, parity, overrun
   task automatic push(input logic p, input logic [3:0] errs);
      @(posedge clk_in);
      rx_push <= p;
      {rx_brk, rx_frm, rx_par, rx_ovr} <= errs;
      rx_data <= rnd();
      @(posedge clk_in);
      rx_push <= 1'b0;
      {rx_brk, rx_frm, rx_par, rx_ovr} <= 4'h0;
      #1;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk_in);
      n_mismatch++;
      $display("Error at %0t: run did not finish", $time);
      wrap_up();
   end
   // ********************************
   // main sequence
   // ********************************
   initial begin
      byte_t r;
      int t;
      {rx_push, rx_ovr, rx_par, rx_frm, rx_brk, rx_tmo, tx_pop, tx_busy, modem} = 9'h000;
      rx_data = 8'h00;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      rd_chk(`OFS_INT_MASK, 8'h00);
      rd_chk(`OFS_LINE_STATUS, 8'h60);
      rd_chk(`OFS_FIFO_CTRL, 8'h01);
      rd_chk(3'h3, 8'h00);
      chk_bit(tx_req_n, 1'b0);
      chk_bit(rx_req_n, 1'b1);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         u_host.bus_write(`OFS_INT_MASK, r & 8'hf0);
         chk_bit(low_pwr, r[5]);
         chk_bit(sleep, r[4]);
         rd_chk(`OFS_INT_MASK, r & 8'h30);
      end
      u_host.bus_write(`OFS_INT_MASK, 8'h08);
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         @(posedge clk_in);
         modem <= r[0];
         tick(0);
         chk_bit(irq, r[0]);
      end
      modem <= 1'b1;
      u_host.bus_write(`OFS_INT_MASK, 8'h00);
      chk_bit(irq, 1'b0);
      modem <= 1'b0;
      u_host.bus_write(`OFS_INT_MASK, 8'h02);
      chk_bit(irq, 1'b1);
      r = rnd();
      u_host.bus_write(`OFS_HOLDING, r);
      chk_bit(irq, 1'b0);
      tick(1);
      chk_bit(tx_req_n, 1'b1);
      chk_byte(tx_data, r);
      rd_chk(`OFS_LINE_STATUS, 8'h00);
      @(posedge clk_in);
      tx_pop <= 1'b1;
      tx_busy <= 1'b1;
      tick(1);
      tx_pop <= 1'b0;
      rd_chk(`OFS_LINE_STATUS, 8'h20);
      tx_busy <= 1'b0;
      rd_chk(`OFS_LINE_STATUS, 8'h60);
      for (int b = 0; b < 2; b++) begin
         for (int c = 0; c < 4; c++) begin
            t = trig_of(b[0], c[1:0]);
            u_host.bus_write(`OFS_FIFO_CTRL, {c[1:0], b[0], 5'h07});
            u_host.bus_write(`OFS_INT_MASK, 8'h01);
            repeat (t - 1) push(1'b1, 4'h0);
            chk_bit(irq, 1'b0);
            push(1'b1, 4'h0);
            chk_bit(irq, 1'b1);
            rd_chk(`OFS_FIFO_CTRL, {2'h3, b[0], 5'h04});
            chk_bit(rx_req_n, 1'b0);
            rd_chk(`OFS_HOLDING, rx_data);
            chk_bit(irq, 1'b0);
            rd_chk(`OFS_FIFO_CTRL, {2'h3, b[0], 5'h01});
         end
      end
      u_host.bus_write(`OFS_FIFO_CTRL, 8'h4f);
      u_host.bus_write(`OFS_INT_MASK, 8'h02);
      chk_bit(irq, 1'b1);
      repeat (3) push(1'b1, 4'h0);
      tick(1);
      chk_bit(rx_req_n, 1'b1);
      repeat (3) push(1'b1, 4'h0);
      tick(1);
      chk_bit(rx_req_n, 1'b0);
      repeat (5) u_host.bus_read(`OFS_HOLDING, rd_val);
      tick(1);
      chk_bit(rx_req_n, 1'b0);
      u_host.bus_read(`OFS_HOLDING, rd_val);
      tick(1);
      chk_bit(rx_req_n, 1'b1);
      repeat (4) u_host.bus_write(`OFS_HOLDING, rnd());
      chk_bit(irq, 1'b0);
      u_host.bus_write(`OFS_FIFO_CTRL, 8'h07);
      u_host.bus_write(`OFS_INT_MASK, 8'h00);
      for (int k = 0; k < 3; k++) begin
         push(1'b1, 4'h2 << k);
         chk_bit(irq, 1'b0);
         rd_chk(`OFS_LINE_STATUS, 8'he1 | (8'h04 << k));
         rd_chk(`OFS_LINE_STATUS, 8'he1);
         u_host.bus_read(`OFS_HOLDING, rd_val);
         rd_chk(`OFS_LINE_STATUS, 8'h60);
      end
      push(1'b0, 4'h1);
      rd_chk(`OFS_LINE_STATUS, 8'h62);
      u_host.bus_write(`OFS_INT_MASK, 8'h04);
      chk_bit(irq, 1'b0);
      push(1'b1, 4'h0);
      chk_bit(irq, 1'b1);
      wrap_up();
   end
endmodule // uart_int_mask_test
